// ---- hw/dgm_consts.vh ----
// Constants for the digitizer gain-match and clock-generator control block
`ifndef DGM_CONSTS_VH
`define DGM_CONSTS_VH

// ****************
// Register offsets
// ****************
`define DGM_OFS_DIV_HIGH     8'h01
`define DGM_OFS_DIV_LOW      8'h02
`define DGM_OFS_PLL_CFG      8'h03
`define DGM_OFS_PHASE        8'h04
`define DGM_OFS_RED_TGT_LO   8'h0B
`define DGM_OFS_RED_TGT_HI   8'h0C
`define DGM_OFS_GRN_TGT_LO   8'h0D
`define DGM_OFS_GRN_TGT_HI   8'h0E
`define DGM_OFS_BLU_TGT_LO   8'h0F
`define DGM_OFS_BLU_TGT_HI   8'h10
`define DGM_OFS_CLAMP_SEL    8'h18
`define DGM_OFS_AUTO_OFS     8'h1B
`define DGM_OFS_SLICER       8'h1D
`define DGM_OFS_CAL_HOLD     8'h2C
`define DGM_OFS_GM_ENABLE    8'h3C
`define DGM_OFS_STATUS       8'h3D

// ****************
// Field positions
// ****************
`define DGM_BIT_GM_ENABLE    2
`define DGM_BIT_GM_HOLD      3
`define DGM_BIT_AO_ENABLE    5
`define DGM_RATE_MSB         4
`define DGM_RATE_LSB         3
`define DGM_SLICE_MSB        7
`define DGM_SLICE_LSB        3
`define DGM_BAND_MSB         7
`define DGM_BAND_LSB         6
`define DGM_PUMP_MSB         5
`define DGM_PUMP_LSB         3
`define DGM_PHASE_MSB        7
`define DGM_PHASE_LSB        3
`define DGM_CLAMP_MSB        3
`define DGM_CLAMP_LSB        1

// ****************
// Reset values
// ****************
`define DGM_RST_BYTE         8'h00
`define DGM_RST_DIV_HIGH     8'h69
`define DGM_RST_DIV_LOW      8'hD0
`define DGM_RST_AUTO_OFS     8'h10
`define DGM_RST_SLICER       8'h78
`define DGM_RST_DIVISOR      12'h69D

// ****************
// Timing counts
// ****************
`define DGM_GM_CYCLES        5'd16
`define DGM_DIV_MIN          12'h002
`define DGM_HS_PER_UPD_0     9'd1
`define DGM_HS_PER_UPD_1     9'd16
`define DGM_HS_PER_UPD_2     9'd64
`define DGM_HS_PER_UPD_3     9'd256

`endif

// ---- hw/dgm_core.v ----
// Gain-match sequencer, slicer, offset targets and clock divider control
`timescale 1ns/1ps
`include "dgm_consts.vh"
// Summary of operation
// - Auto gain matching trims channel gains until they agree within one percent.
// - Each match takes 16 data clocks, starting right after clamp ends.
// - Data outputs freeze at their last value while matching runs.
// - Hold bit 3 at 0x2C picks one-time or continuous matching.
// - Continuous update interval follows 0x1B bits 4:3; 64 syncs recommended.
// - Slicer threshold sits above negative peak by 0x1D bits 7:3.
// - Sync extracted from green is always treated as active low.
// - Pixel clock divided by divisor is phase-compared with horizontal sync.
// - Generated pixel clock is supported only from 10 to 170 MHz.
// - Two band bits select four overlapping oscillator ranges.
// - Three pump bits map to 50 through 1500 microamps.
// - Divisor, band, pump current and 5-bit phase are programmable.
// - Offset targets are nine-bit two's complement; zero is invalid.
module dgm_core #(
  parameter DATA_W = 8,
  parameter TRIM_W = 7
) (
  input  wire                clock,
  input  wire                sys_rst,
  input  wire [7:0]          reg_addr,
  input  wire                reg_wr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata,
  input  wire                clamp_pin,
  input  wire                hsync_pin,
  input  wire [DATA_W-1:0]   red_in,
  input  wire [DATA_W-1:0]   green_in,
  input  wire [DATA_W-1:0]   blue_in,
  output reg  [DATA_W-1:0]   red_out,
  output reg  [DATA_W-1:0]   green_out,
  output reg  [DATA_W-1:0]   blue_out,
  output reg  [TRIM_W-1:0]   red_trim,
  output reg  [TRIM_W-1:0]   blue_trim,
  output wire                gain_match_busy,
  output reg                 green_sync_n,
  output reg  [8:0]          red_target,
  output reg  [8:0]          green_target,
  output reg  [8:0]          blue_target,
  output reg                 target_invalid,
  output reg  [2:0]          clamp_midscale,
  output reg                 auto_offset_on,
  output reg                 fb_pulse,
  output reg                 pump_up,
  output reg                 pump_down,
  output reg                 osc_band_bit_high,
  output reg                 osc_band_bit_low,
  output reg                 pump_current_bit2,
  output reg                 pump_current_bit1,
  output reg                 pump_current_bit0,
  output reg  [10:0]         pump_current_ua,
  output reg  [4:0]          phase_adjust
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  // ****************
  // Helper functions
  // ****************
  function [10:0] pump_ua;
    input [2:0] code;
    begin
      case (code)
        3'h0:    pump_ua = 11'd50;
        3'h1:    pump_ua = 11'd100;
        3'h2:    pump_ua = 11'd150;
        3'h3:    pump_ua = 11'd250;
        3'h4:    pump_ua = 11'd350;
        3'h5:    pump_ua = 11'd500;
        3'h6:    pump_ua = 11'd750;
        default: pump_ua = 11'd1500;
      endcase
    end
  endfunction

  function [8:0] hs_per_update;
    input [1:0] rate;
    begin
      case (rate)
        2'h0:    hs_per_update = `DGM_HS_PER_UPD_0;
        2'h1:    hs_per_update = `DGM_HS_PER_UPD_1;
        2'h2:    hs_per_update = `DGM_HS_PER_UPD_2;
        default: hs_per_update = `DGM_HS_PER_UPD_3;
      endcase
    end
  endfunction

  // Target: low byte is target bits 8:1, upper register bit 7 is bit 0
  function [8:0] tgt;
    input [7:0] lo;
    input [7:0] hi;
    begin
      tgt = {lo, hi[7]};
    end
  endfunction

  // ****************
  // Register file
  // ****************
  reg [7:0] div_high_reg;
  reg [7:0] div_low_reg;
  reg [7:0] pll_cfg_reg;
  reg [7:0] phase_reg;
  reg [7:0] tgt_reg [0:5];
  reg [7:0] clamp_sel_reg;
  reg [7:0] auto_ofs_reg;
  reg [7:0] slicer_reg;
  reg [7:0] cal_hold_reg;
  reg [7:0] gm_enable_reg;
  reg       div_high_seen_reg;
  reg [11:0] divisor_reg;
  reg       done_once_reg;
  integer   i;

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_high_reg      <= `DGM_RST_DIV_HIGH;
      div_low_reg       <= `DGM_RST_DIV_LOW;
      pll_cfg_reg       <= `DGM_RST_BYTE;
      phase_reg         <= `DGM_RST_BYTE;
      for (i = 0; i < 6; i = i + 1)
        tgt_reg[i]      <= `DGM_RST_BYTE;
      clamp_sel_reg     <= `DGM_RST_BYTE;
      auto_ofs_reg      <= `DGM_RST_AUTO_OFS;
      slicer_reg        <= `DGM_RST_SLICER;
      cal_hold_reg      <= `DGM_RST_BYTE;
      gm_enable_reg     <= `DGM_RST_BYTE;
      div_high_seen_reg <= 1'b0;
      divisor_reg       <= `DGM_RST_DIVISOR;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `DGM_OFS_DIV_HIGH:
        begin
          div_high_reg      <= reg_wdata;
          div_high_seen_reg <= 1'b1;
        end
        `DGM_OFS_DIV_LOW:
        begin
          div_low_reg <= reg_wdata;
          // Commit only as a pair so the divider never sees half a value
          if (div_high_seen_reg)
          begin
            divisor_reg       <= {div_high_reg, reg_wdata[7:4]};
            div_high_seen_reg <= 1'b0;
          end
        end
        `DGM_OFS_PLL_CFG:    pll_cfg_reg   <= reg_wdata;
        `DGM_OFS_PHASE:      phase_reg     <= reg_wdata;
        `DGM_OFS_RED_TGT_LO: tgt_reg[0]    <= reg_wdata;
        `DGM_OFS_RED_TGT_HI: tgt_reg[1]    <= reg_wdata;
        `DGM_OFS_GRN_TGT_LO: tgt_reg[2]    <= reg_wdata;
        `DGM_OFS_GRN_TGT_HI: tgt_reg[3]    <= reg_wdata;
        `DGM_OFS_BLU_TGT_LO: tgt_reg[4]    <= reg_wdata;
        `DGM_OFS_BLU_TGT_HI: tgt_reg[5]    <= reg_wdata;
        `DGM_OFS_CLAMP_SEL:  clamp_sel_reg <= reg_wdata;
        `DGM_OFS_AUTO_OFS:   auto_ofs_reg  <= reg_wdata;
        `DGM_OFS_SLICER:     slicer_reg    <= reg_wdata;
        `DGM_OFS_CAL_HOLD:   cal_hold_reg  <= reg_wdata;
        `DGM_OFS_GM_ENABLE:  gm_enable_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Unmapped addresses read zero
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `DGM_OFS_DIV_HIGH:   reg_rdata <= div_high_reg;
        `DGM_OFS_DIV_LOW:    reg_rdata <= div_low_reg;
        `DGM_OFS_PLL_CFG:    reg_rdata <= pll_cfg_reg;
        `DGM_OFS_PHASE:      reg_rdata <= phase_reg;
        `DGM_OFS_RED_TGT_LO: reg_rdata <= tgt_reg[0];
        `DGM_OFS_RED_TGT_HI: reg_rdata <= tgt_reg[1];
        `DGM_OFS_GRN_TGT_LO: reg_rdata <= tgt_reg[2];
        `DGM_OFS_GRN_TGT_HI: reg_rdata <= tgt_reg[3];
        `DGM_OFS_BLU_TGT_LO: reg_rdata <= tgt_reg[4];
        `DGM_OFS_BLU_TGT_HI: reg_rdata <= tgt_reg[5];
        `DGM_OFS_CLAMP_SEL:  reg_rdata <= clamp_sel_reg;
        `DGM_OFS_AUTO_OFS:   reg_rdata <= auto_ofs_reg;
        `DGM_OFS_SLICER:     reg_rdata <= slicer_reg;
        `DGM_OFS_CAL_HOLD:   reg_rdata <= cal_hold_reg;
        `DGM_OFS_GM_ENABLE:  reg_rdata <= gm_enable_reg;
        `DGM_OFS_STATUS:
          reg_rdata <= {6'h00, done_once_reg, gain_match_busy};
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************
  // Pin synchronisers
  // ****************
  reg [1:0] clamp_sync_reg;
  reg [1:0] hs_sync_reg;
  reg       clamp_last_reg;
  reg       hs_last_reg;
  wire      clamp_end = clamp_last_reg & ~clamp_sync_reg[1];
  wire      hs_rise   = hs_sync_reg[1] & ~hs_last_reg;

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clamp_sync_reg <= 2'b00;
      hs_sync_reg    <= 2'b00;
      clamp_last_reg <= 1'b0;
      hs_last_reg    <= 1'b0;
    end
    else
    begin
      clamp_sync_reg <= {clamp_sync_reg[0], clamp_pin};
      hs_sync_reg    <= {hs_sync_reg[0], hsync_pin};
      clamp_last_reg <= clamp_sync_reg[1];
      hs_last_reg    <= hs_sync_reg[1];
    end
  end

  // ****************
  // Gain-match sequencer
  // ****************
  reg                state_reg;
  reg [4:0]          cyc_reg;
  reg [8:0]          hs_cnt_reg;
  reg [DATA_W+3:0]   sum_r_reg;
  reg [DATA_W+3:0]   sum_g_reg;
  reg [DATA_W+3:0]   sum_b_reg;
  wire               gm_on   = gm_enable_reg[`DGM_BIT_GM_ENABLE];
  wire               hold    = cal_hold_reg[`DGM_BIT_GM_HOLD];
  wire [8:0]         period  =
    hs_per_update(auto_ofs_reg[`DGM_RATE_MSB:`DGM_RATE_LSB]);
  wire               due     = (hs_cnt_reg >= period);
  // One-time mode runs once; continuous mode waits for the interval
  wire               start   = gm_on & clamp_end & (state_reg == ST_IDLE) &
                               (hold ? ~done_once_reg : due);
  wire               last    = (state_reg == ST_RUN) &&
                               (cyc_reg == `DGM_GM_CYCLES - 5'd1);
  assign gain_match_busy = (state_reg == ST_RUN);

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg     <= ST_IDLE;
      cyc_reg       <= 5'd0;
      hs_cnt_reg    <= 9'd0;
      done_once_reg <= 1'b0;
      sum_r_reg     <= {(DATA_W+4){1'b0}};
      sum_g_reg     <= {(DATA_W+4){1'b0}};
      sum_b_reg     <= {(DATA_W+4){1'b0}};
    end
    else
    begin
      if (start)
        hs_cnt_reg <= 9'd0;
      else if (hs_rise && !due)
        hs_cnt_reg <= hs_cnt_reg + 9'd1;
      if (!gm_on || !hold)
        done_once_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            state_reg <= ST_RUN;
            cyc_reg   <= 5'd0;
            sum_r_reg <= {(DATA_W+4){1'b0}};
            sum_g_reg <= {(DATA_W+4){1'b0}};
            sum_b_reg <= {(DATA_W+4){1'b0}};
          end
        end
        ST_RUN:
        begin
          sum_r_reg <= sum_r_reg + {4'h0, red_in};
          sum_g_reg <= sum_g_reg + {4'h0, green_in};
          sum_b_reg <= sum_b_reg + {4'h0, blue_in};
          cyc_reg   <= cyc_reg + 5'd1;
          if (last)
          begin
            state_reg <= ST_IDLE;
            if (hold)
              done_once_reg <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Green is the reference; a 1 percent dead band keeps trims from dithering
  wire [DATA_W+3:0] sum_r_fin = sum_r_reg + {4'h0, red_in};
  wire [DATA_W+3:0] sum_g_fin = sum_g_reg + {4'h0, green_in};
  wire [DATA_W+3:0] sum_b_fin = sum_b_reg + {4'h0, blue_in};
  wire [DATA_W+3:0] band      = sum_g_fin / 7'h64;
  localparam [TRIM_W-1:0] TRIM_MAX = {TRIM_W{1'b1}};
  localparam [TRIM_W-1:0] TRIM_MID = {1'b1, {(TRIM_W-1){1'b0}}};

  // Higher trim code means lower gain
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      red_trim  <= TRIM_MID;
      blue_trim <= TRIM_MID;
    end
    else if (last)
    begin
      if (sum_r_fin > {1'b0, sum_g_fin} + band && red_trim != TRIM_MAX)
        red_trim <= red_trim + 1'b1;
      else if ({1'b0, sum_r_fin} + band < sum_g_fin && red_trim != 0)
        red_trim <= red_trim - 1'b1;
      if (sum_b_fin > {1'b0, sum_g_fin} + band && blue_trim != TRIM_MAX)
        blue_trim <= blue_trim + 1'b1;
      else if ({1'b0, sum_b_fin} + band < sum_g_fin && blue_trim != 0)
        blue_trim <= blue_trim - 1'b1;
    end
  end

  // Outputs keep the pre-operation sample until the sequencer idles
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      red_out   <= {DATA_W{1'b0}};
      green_out <= {DATA_W{1'b0}};
      blue_out  <= {DATA_W{1'b0}};
    end
    else if (!start && !gain_match_busy)
    begin
      red_out   <= red_in;
      green_out <= green_in;
      blue_out  <= blue_in;
    end
  end

  // ****************
  // Green sync slicer
  // ****************
  reg [DATA_W-1:0] neg_peak_reg;
  wire [DATA_W:0]  thresh = {1'b0, neg_peak_reg} +
    {{(DATA_W-4){1'b0}}, slicer_reg[`DGM_SLICE_MSB:`DGM_SLICE_LSB]};

  // Peak decays one code per line so it follows slow level drift
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      neg_peak_reg <= {DATA_W{1'b1}};
      green_sync_n <= 1'b1;
    end
    else
    begin
      if (green_in < neg_peak_reg)
        neg_peak_reg <= green_in;
      else if (hs_rise && neg_peak_reg != {DATA_W{1'b1}})
        neg_peak_reg <= neg_peak_reg + 1'b1;
      green_sync_n <= ~({1'b0, green_in} < thresh);
    end
  end

  // ****************
  // Targets, clamp and clock settings
  // ****************
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      red_target        <= 9'h000;
      green_target      <= 9'h000;
      blue_target       <= 9'h000;
      target_invalid    <= 1'b1;
      clamp_midscale    <= 3'b000;
      auto_offset_on    <= 1'b0;
      osc_band_bit_high <= 1'b0;
      osc_band_bit_low  <= 1'b0;
      pump_current_bit2 <= 1'b0;
      pump_current_bit1 <= 1'b0;
      pump_current_bit0 <= 1'b0;
      pump_current_ua   <= 11'd50;
      phase_adjust      <= 5'h00;
    end
    else
    begin
      red_target     <= tgt(tgt_reg[0], tgt_reg[1]);
      green_target   <= tgt(tgt_reg[2], tgt_reg[3]);
      blue_target    <= tgt(tgt_reg[4], tgt_reg[5]);
      target_invalid <= (tgt(tgt_reg[0], tgt_reg[1]) == 9'h000) |
                        (tgt(tgt_reg[2], tgt_reg[3]) == 9'h000) |
                        (tgt(tgt_reg[4], tgt_reg[5]) == 9'h000);
      clamp_midscale <= clamp_sel_reg[`DGM_CLAMP_MSB:`DGM_CLAMP_LSB];
      auto_offset_on <= auto_ofs_reg[`DGM_BIT_AO_ENABLE];
      {osc_band_bit_high, osc_band_bit_low} <=
        pll_cfg_reg[`DGM_BAND_MSB:`DGM_BAND_LSB];
      {pump_current_bit2, pump_current_bit1, pump_current_bit0} <=
        pll_cfg_reg[`DGM_PUMP_MSB:`DGM_PUMP_LSB];
      pump_current_ua <=
        pump_ua(pll_cfg_reg[`DGM_PUMP_MSB:`DGM_PUMP_LSB]);
      phase_adjust <= phase_reg[`DGM_PHASE_MSB:`DGM_PHASE_LSB];
    end
  end

  // ****************
  // Feedback divider and phase compare
  // ****************
  reg [11:0] div_cnt_reg;
  // Divisors below the legal minimum are clamped rather than stalling
  wire [11:0] div_eff = (divisor_reg < `DGM_DIV_MIN) ? `DGM_DIV_MIN
                                                     : divisor_reg;
  wire        div_wrap = (div_cnt_reg >= div_eff - 12'd1);

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_cnt_reg <= 12'h000;
      fb_pulse    <= 1'b0;
      pump_up     <= 1'b0;
      pump_down   <= 1'b0;
    end
    else
    begin
      div_cnt_reg <= div_wrap ? 12'h000 : div_cnt_reg + 12'd1;
      fb_pulse    <= div_wrap;
      // Sync first: speed up until feedback; feedback first: slow down
      if (hs_rise && div_wrap)
      begin
        pump_up   <= 1'b0;
        pump_down <= 1'b0;
      end
      else if (hs_rise)
      begin
        if (pump_down)
          pump_down <= 1'b0;
        else
          pump_up <= 1'b1;
      end
      else if (div_wrap)
      begin
        if (pump_up)
          pump_up <= 1'b0;
        else
          pump_down <= 1'b1;
      end
    end
  end

endmodule // dgm_core

// ---- verif/dgm_monitor.sv ----
// Assertion checker for the gain-match and clock control block
`timescale 1ns/1ps
module dgm_monitor #(
  parameter DATA_W = 8
) (
  input wire              clock,
  input wire              sys_rst,
  input wire [7:0]        reg_addr,
  input wire              reg_wr,
  input wire [7:0]        reg_wdata,
  input wire [DATA_W-1:0] red_in,
  input wire [DATA_W-1:0] red_out,
  input wire [DATA_W-1:0] green_out,
  input wire [DATA_W-1:0] blue_out,
  input wire              gain_match_busy,
  input wire [8:0]        red_target,
  input wire [8:0]        green_target,
  input wire [8:0]        blue_target,
  input wire              target_invalid,
  input wire [2:0]        clamp_midscale,
  input wire              auto_offset_on,
  input wire              osc_band_bit_high,
  input wire              osc_band_bit_low,
  input wire              pump_current_bit2,
  input wire              pump_current_bit1,
  input wire              pump_current_bit0,
  input wire [10:0]       pump_current_ua,
  input wire [4:0]        phase_adjust
);
  localparam logic [10:0] UA_TAB [8] = '{11'h032, 11'h064, 11'h096,
    11'h0FA, 11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};
  reg [4:0] busy_cnt;

  // ****************
  // Busy run length
  // ****************
  always @(posedge clock or posedge sys_rst)
    if (sys_rst)
      busy_cnt <= 5'h00;
    else
      busy_cnt <= gain_match_busy ? busy_cnt + 5'h01 : 5'h00;

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_BUSY_LEN:
    assert property ($fell(gain_match_busy) |-> busy_cnt == 5'h10)
    else $error("match window shorter than 16 cycles");
  AST_BUSY_MAX:
    assert property (gain_match_busy |-> busy_cnt < 5'h10)
    else $error("match window longer than 16 cycles");
  AST_FREEZE:
    assert property (gain_match_busy && $past(gain_match_busy) |->
      $stable({red_out, green_out, blue_out}))
    else $error("data moved during gain match");
  AST_FOLLOW:
    assert property (!gain_match_busy && !$past(gain_match_busy) &&
      !$past(sys_rst) |-> red_out == $past(red_in))
    else $error("data does not follow input");
  AST_CLAMP:
    assert property (reg_wr && reg_addr == 8'h18 |->
      ##2 clamp_midscale == $past(reg_wdata[3:1], 2))
    else $error("clamp select not applied");
  AST_AO_ON:
    assert property (reg_wr && reg_addr == 8'h1B |->
      ##2 auto_offset_on == $past(reg_wdata[5], 2))
    else $error("auto offset enable not applied");
  AST_BAND:
    assert property (reg_wr && reg_addr == 8'h03 |-> ##2
      {osc_band_bit_high, osc_band_bit_low} == $past(reg_wdata[7:6], 2))
    else $error("band bits not applied");
  AST_PHASE:
    assert property (reg_wr && reg_addr == 8'h04 |->
      ##2 phase_adjust == $past(reg_wdata[7:3], 2))
    else $error("phase not applied");
  AST_PUMP_UA:
    assert property ($stable({pump_current_bit2, pump_current_bit1,
      pump_current_bit0}) |-> pump_current_ua == UA_TAB[{pump_current_bit2,
      pump_current_bit1, pump_current_bit0}])
    else $error("pump current does not match code");
  AST_TGT_ZERO:
    assert property ($stable({red_target, green_target, blue_target}) |->
      target_invalid == (red_target == 9'h000 || green_target == 9'h000 ||
      blue_target == 9'h000))
    else $error("zero target flag wrong");
endmodule // dgm_monitor

bind dgm_core dgm_monitor #(.DATA_W(DATA_W)) u_mon (.clock, .sys_rst,
  .reg_addr, .reg_wr, .reg_wdata, .red_in, .red_out, .green_out,
  .blue_out, .gain_match_busy, .red_target, .green_target, .blue_target,
  .target_invalid, .clamp_midscale, .auto_offset_on, .osc_band_bit_high,
  .osc_band_bit_low, .pump_current_bit2, .pump_current_bit1,
  .pump_current_bit0, .pump_current_ua, .phase_adjust);

// ---- verif/dgm_src.sv ----
// Video source model: sync, clamp and moving samples
`timescale 1ns/1ps
module dgm_src (
  input  wire       clock,
  output reg        clamp_pin,
  output reg        hsync_pin,
  output reg  [7:0] red_in,
  output reg  [7:0] green_in,
  output reg  [7:0] blue_in
);
  initial
  begin
    clamp_pin = 1'b0;
    hsync_pin = 1'b0;
    red_in = 8'h11;
    green_in = 8'h22;
    blue_in = 8'h33;
  end

  // Samples move every cycle so a stale hold is visible
  always @(negedge clock)
  begin
    red_in <= red_in + 8'h03;
    green_in <= green_in + 8'h05;
    blue_in <= blue_in + 8'h07;
  end

  // One line: sync, back-porch clamp, then active video
  task line(input integer gap);
    @(negedge clock);
    hsync_pin = 1'b1;
    repeat (4) @(negedge clock);
    hsync_pin = 1'b0;
    clamp_pin = 1'b1;
    repeat (8) @(negedge clock);
    clamp_pin = 1'b0;
    repeat (gap) @(negedge clock);
  endtask
endmodule // dgm_src

// ---- verif/tb_top.sv ----
// Self-checking bench for the gain-match and clock control block
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] RA [14] = '{8'h01, 8'h02, 8'h0B, 8'h0C, 8'h0D,
    8'h0E, 8'h0F, 8'h10, 8'h18, 8'h1B, 8'h1D, 8'h2C, 8'h3C, 8'h50};
  localparam logic [7:0] RV [14] = '{8'h69, 8'hD0, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h78, 8'h00, 8'h00, 8'h00};
  localparam logic [10:0] UA [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
    11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};
  reg         clock, sys_rst, reg_wr, reg_rd;
  reg  [7:0]  reg_addr, reg_wdata;
  wire        clamp_pin, hsync_pin, gain_match_busy, green_sync_n;
  wire        target_invalid, auto_offset_on, fb_pulse, pump_up, pump_down;
  wire        osc_band_bit_high, osc_band_bit_low;
  wire        pump_current_bit2, pump_current_bit1, pump_current_bit0;
  wire [7:0]  red_in, green_in, blue_in, reg_rdata;
  wire [6:0]  red_trim, blue_trim;
  wire [8:0]  red_target, green_target, blue_target;
  wire [2:0]  clamp_midscale;
  wire [10:0] pump_current_ua;
  wire [4:0]  phase_adjust;
  integer     fails = 0, num_checks = 0, cyc = 0;

  dgm_core u_dut (.clock, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .clamp_pin, .hsync_pin, .red_in, .green_in,
    .blue_in, .red_out(), .green_out(), .blue_out(), .red_trim,
    .blue_trim, .gain_match_busy, .green_sync_n, .red_target,
    .green_target, .blue_target, .target_invalid, .clamp_midscale,
    .auto_offset_on, .fb_pulse, .pump_up, .pump_down,
    .osc_band_bit_high, .osc_band_bit_low, .pump_current_bit2,
    .pump_current_bit1, .pump_current_bit0, .pump_current_ua,
    .phase_adjust);
  dgm_src u_src (.clock, .clamp_pin, .hsync_pin, .red_in, .green_in,
    .blue_in);

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ****************
  // Shared tasks
  // ****************
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // Second pass measures a whole period under the new divisor
  task per_chk(input logic [31:0] e);
    integer n, p;
    repeat (2)
    begin
      n = 0;
      while (fb_pulse !== 1'b1 && n < 5000)
      begin
        @(negedge clock);
        n++;
      end
      p = 0;
      do
      begin
        @(negedge clock);
        p++;
      end
      while (fb_pulse !== 1'b1 && p < 5000);
    end
    chk("feedback period", e, p);
  endtask

  task run_line(output integer hi, output integer ri, output integer fi);
    integer i;
    reg     prev;
    hi = 0;
    ri = 0;
    fi = 0;
    prev = 1'b0;
    fork
      u_src.line(40);
      for (i = 1; i <= 52; i++)
      begin
        @(negedge clock);
        if (gain_match_busy === 1'b1)
        begin
          hi++;
          if (!prev)
            ri++;
          if (fi == 0)
            fi = i;
        end
        prev = (gain_match_busy === 1'b1);
      end
    join
  endtask

  // ****************
  // Scenarios
  // ****************
  task t_reset;
    logic [7:0] d;
    integer     k;
    for (k = 0; k < 14; k++)
    begin
      rd(RA[k], d);
      chk("reset register", RV[k], d);
    end
    chk("red trim", 7'h40, red_trim);
    chk("blue trim", 7'h40, blue_trim);
    chk("green sync idle", 1'b1, green_sync_n);
    chk("pump ua", 11'h032, pump_current_ua);
    k = 0;
    while (green_sync_n !== 1'b0 && k < 300)
    begin
      @(negedge clock);
      k++;
    end
    chk("green sync pulse", 1, k < 300);
  endtask

  task t_ypbpr;
    logic [7:0] d;
    wr(8'h1B, 8'h30);
    wr(8'h0B, 8'h40);
    wr(8'h0C, 8'h00);
    wr(8'h0D, 8'h02);
    wr(8'h0E, 8'h00);
    wr(8'h0F, 8'h40);
    wr(8'h10, 8'h00);
    wr(8'h18, 8'h0A);
    wr(8'h50, 8'hFF);
    repeat (2) @(negedge clock);
    chk("red target", 9'h080, red_target);
    chk("green target", 9'h004, green_target);
    chk("blue target", 9'h080, blue_target);
    chk("target flag", 1'b0, target_invalid);
    chk("clamp select", 3'h5, clamp_midscale);
    chk("auto offset", 1'b1, auto_offset_on);
    rd(8'h1B, d);
    chk("offset reg", 8'h30, d);
    rd(8'h50, d);
    chk("unmapped", 8'h00, d);
    wr(8'h0D, 8'h00);
    repeat (2) @(negedge clock);
    chk("zero target", 1'b1, target_invalid);
    wr(8'h0D, 8'h02);
  endtask

  task t_pll;
    integer c;
    for (c = 0; c < 8; c++)
    begin
      wr(8'h03, {c[1:0], c[2:0], 3'h0});
      wr(8'h04, {c[2:0], c[1:0], 3'h0});
      repeat (2) @(negedge clock);
      chk("pump bits", c[2:0], {pump_current_bit2, pump_current_bit1,
        pump_current_bit0});
      chk("band", c[1:0], {osc_band_bit_high, osc_band_bit_low});
      chk("pump ua", UA[c], pump_current_ua);
      chk("phase", {c[2:0], c[1:0]}, phase_adjust);
    end
  endtask

  task t_div;
    per_chk(32'h69D);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'hA0);
    per_chk(32'h00A);
    chk("pump dir", 2'b01, {pump_up, pump_down});
    wr(8'h01, 8'h01);
    per_chk(32'h00A);
    wr(8'h02, 8'h40);
    per_chk(32'h014);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h20);
    per_chk(32'h002);
  endtask

  task t_gm;
    integer hi, ri, fi, r, k, s;
    run_line(hi, ri, fi);
    chk("match while off", 0, hi);
    wr(8'h2C, 8'h08);
    wr(8'h3C, 8'h04);
    run_line(hi, ri, fi);
    chk("match cycles", 16, hi);
    chk("match starts", 1, ri);
    chk("match start", 1, fi >= 15 && fi <= 20);
    run_line(hi, ri, fi);
    chk("one time match", 0, hi);
    wr(8'h2C, 8'h00);
    wr(8'h1B, 8'h20);
    run_line(hi, ri, fi);
    chk("every sync", 16, hi);
    for (r = 1; r < 4; r++)
    begin
      wr(8'h1B, {3'h4, r[1:0], 3'h0});
      s = 0;
      for (k = 0; k <= 2 * (16 << (2 * (r - 1))); k++)
      begin
        run_line(hi, ri, fi);
        s = s + ri;
      end
      chk("update starts", 1, s >= 2 && s <= 3);
    end
  endtask

  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    t_reset;
    t_ypbpr;
    t_pll;
    t_div;
    t_gm;
    finish_test;
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      finish_test;
    end
  end
endmodule // tb_top
